// >>> logic/isr_errq.sv
// twenty-entry first-in first-out error queue
module isr_errq
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control side
   isr_errq_if.queue q
);
   logic [15:0] mem_ff [isr_pkg::ERRQ_DEPTH];
   logic [4:0] rd_ff;
   logic [4:0] wr_ff;
   logic [4:0] cnt_ff;
   logic full_w;
   logic do_push_w;
   logic do_pop_w;
   logic [4:0] last_w;

   assign full_w = (cnt_ff == 5'(isr_pkg::ERRQ_DEPTH));
   assign do_pop_w = q.pop && (cnt_ff != 5'h00);
   assign do_push_w = q.push && !full_w;
   assign last_w = (wr_ff == 5'h00) ? 5'(isr_pkg::ERRQ_DEPTH - 1) : wr_ff - 5'h01;
   assign q.head = (cnt_ff == 5'h00) ? isr_pkg::ERR_NONE : mem_ff[rd_ff];
   assign q.empty = (cnt_ff == 5'h00);

   function automatic logic [4:0] wrap_inc(input logic [4:0] p);
      return (p == 5'(isr_pkg::ERRQ_DEPTH - 1)) ? 5'h00 : p + 5'h01;
   endfunction

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_ff <= 5'h00;
         wr_ff <= 5'h00;
         cnt_ff <= 5'h00;
      end
      else if (q.flush)
      begin
         rd_ff <= 5'h00;
         wr_ff <= 5'h00;
         cnt_ff <= 5'h00;
      end
      else
      begin
         if (do_push_w)
            wr_ff <= wrap_inc(wr_ff);
         if (do_pop_w)
            rd_ff <= wrap_inc(rd_ff);
         cnt_ff <= cnt_ff + 5'(do_push_w) - 5'(do_pop_w);
      end
   end

   // overflow replaces the newest entry, stores nothing more
   always_ff @(posedge hclk)
   begin
      if (do_push_w)
         mem_ff[wr_ff] <= q.push_code;
      else if (q.push && full_w && !do_pop_w)
         mem_ff[last_w] <= isr_pkg::ERR_OVERFLOW;
   end

   a_errq_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      cnt_ff <= 5'(isr_pkg::ERRQ_DEPTH))
      else $error("error queue count above depth");
endmodule

// >>> logic/isr_errq_if.sv
// carrier between the control logic and the error queue
interface isr_errq_if;
   logic push;
   logic [15:0] push_code;
   logic pop;
   logic flush;
   logic [15:0] head;
   logic empty;
   modport ctrl (output push, output push_code, output pop, output flush,
      input head, input empty);
   modport queue (input push, input push_code, input pop, input flush,
      output head, output empty);
endinterface

// >>> logic/isr_pkg.sv
// constants and types shared by the status reporting unit
package isr_pkg;
   // register byte addresses
   localparam logic [7:0] OFF_STB = 8'h00;
   localparam logic [7:0] OFF_SRE = 8'h04;
   localparam logic [7:0] OFF_ESR = 8'h08;
   localparam logic [7:0] OFF_ESE = 8'h0C;
   localparam logic [7:0] OFF_QCOND = 8'h10;
   localparam logic [7:0] OFF_QEVT = 8'h14;
   localparam logic [7:0] OFF_QENA = 8'h18;
   localparam logic [7:0] OFF_PSC = 8'h1C;
   localparam logic [7:0] OFF_ERRQ = 8'h20;
   localparam logic [7:0] OFF_CMD = 8'h24;
   localparam logic [7:0] OFF_EVSET = 8'h28;
   localparam logic [7:0] OFF_MSG = 8'h2C;
   localparam logic [7:0] OFF_STAT = 8'h30;
   localparam logic [7:0] OFF_POLL = 8'h34;
   // status byte bit positions
   localparam int STB_QUES = 3;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_RQS = 6;
   // standard event bit positions
   localparam int ESR_OPC = 0;
   localparam int ESR_QYE = 2;
   localparam int ESR_DDE = 3;
   localparam int ESR_EXE = 4;
   localparam int ESR_CME = 5;
   localparam int ESR_PON = 7;
   localparam logic [7:0] ESR_USED = 8'hBD;
   localparam logic [7:0] QUES_USED = 8'h03;
   // command register bit positions
   localparam int CMD_CLS = 0;
   localparam int CMD_OPC = 1;
   localparam int CMD_OPCQ = 2;
   localparam int CMD_DCL = 3;
   localparam int CMD_WAI = 4;
   localparam int CMD_TRIGMODE = 5;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_PSC = 1'b1;
   // error queue
   localparam int ERRQ_DEPTH = 20;
   localparam int ERRQ_AW = 5;
   localparam int ERR_W = 16;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;
   // output buffer depth
   localparam int OBUF_DEPTH = 8;
   localparam int OBUF_CW = 4;
   localparam logic [7:0] OPCQ_REPLY = 8'h01;
endpackage

// >>> logic/isr_status.sv
// status reporting unit: status byte, event registers, error queue, ahb-lite slave
// Summary of operation
// - message-available stays set until every pending output byte is read
// - finished operation-complete command sets standard event bit 0
// - operation-complete query puts 1 in the output buffer after prior work
// - questionable condition is live regulation state, 0..3, unlatched
// - questionable event latches; reading returns value then clears it
// - questionable enable selects event bits into status byte bit 3
// - clear-status zeroes every event register and the status byte except message-available
// - standard event enable selects bits ORed into status byte bit 5
// - status byte enable 32 lets standard event summary request service
// - power-on clear flag: 1 clears both masks at power-up, 0 keeps them
// - mask reads return the plain binary weighted value
// - status byte query equals serial poll but keeps request-service
// - up to 20 errors queued first-in first-out, oldest read first
// - reading the last error turns off the error indicator
// - device clear flushes buffers only; status, errors and config kept
// - control-c acts as device clear; handshake line then driven true
// - full output buffer before operation-complete stops command processing
// - wait holds later commands until pending work ends, triggered mode only
// - status byte bits: 3 questionable, 4 message, 5 event, 6 service
// - enabled summary bit becoming true sets request-service and service line
// - serial poll clears only request-service
// - standard event bits: 0,2,3,4,5,7 as documented
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
module isr_status
(
   // ahb-lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // instrument side
   input wire logic [1:0] reg_state,
   input wire logic ops_pending,
   input wire logic power_on,
   input wire logic ctrl_c,
   input wire logic [15:0] err_code,
   input wire logic err_push,
   input wire logic [7:0] resp_byte,
   input wire logic resp_push,
   // status outputs
   output logic srq_out,
   output logic error_led,
   output logic cmd_hold,
   output logic dtr_out,
   output logic obuf_flush
);
   // -------------------------------------------------
   // bus address phase capture
   // -------------------------------------------------
   logic wr_ff;
   logic rd_ff;
   logic [7:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic take_w;

   assign take_w = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= 8'h00;
      end
      else
      begin
         wr_ff <= take_w && hwrite;
         rd_ff <= take_w && !hwrite;
         addr_ff <= haddr;
      end
   end

   function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] o);
      return stb && (a == o);
   endfunction

   // -------------------------------------------------
   // register state
   // -------------------------------------------------
   logic [7:0] esr_ff;
   logic [7:0] ese_ff;
   logic [7:0] sre_ff;
   logic [7:0] qevt_ff;
   logic [7:0] qena_ff;
   logic [1:0] qcond_ff;
   logic psc_ff;
   logic rqs_ff;
   logic srq_ff;
   logic opc_pend_ff;
   logic opcq_pend_ff;
   logic wai_ff;
   logic trig_mode_ff;
   logic dtr_ff;
   logic flush_ff;
   logic err_led_ff;
   logic pwr_ff;
   logic [7:0] obuf_ff [isr_pkg::OBUF_DEPTH];
   logic [2:0] orp_ff;
   logic [2:0] owp_ff;
   logic [3:0] ocnt_ff;

   isr_errq_if eq ();
   isr_errq u_errq (.hclk(hclk), .hresetn(hresetn), .q(eq));

   // -------------------------------------------------
   // decode
   // -------------------------------------------------
   logic wr_sre, wr_ese, wr_qena, wr_psc, wr_cmd, wr_evset;
   logic rd_esr, rd_qevt, rd_errq, rd_msg, rd_poll;
   logic [7:0] wd;
   logic cls_w, opc_cmd_w, opcq_cmd_w, dcl_w, wai_cmd_w;
   logic obuf_full_w, obuf_empty_w, obuf_pop_w, obuf_push_w;
   logic opc_done_w, opcq_done_w, opcq_push_w;
   logic [7:0] stb_w;
   logic ques_sum_w, esb_sum_w, summ_req_w;

   assign wd = hwdata[7:0];
   assign wr_sre = hit(wr_ff, addr_ff, isr_pkg::OFF_SRE);
   assign wr_ese = hit(wr_ff, addr_ff, isr_pkg::OFF_ESE);
   assign wr_qena = hit(wr_ff, addr_ff, isr_pkg::OFF_QENA);
   assign wr_psc = hit(wr_ff, addr_ff, isr_pkg::OFF_PSC);
   assign wr_cmd = hit(wr_ff, addr_ff, isr_pkg::OFF_CMD);
   assign wr_evset = hit(wr_ff, addr_ff, isr_pkg::OFF_EVSET);
   assign rd_esr = hit(rd_ff, addr_ff, isr_pkg::OFF_ESR);
   assign rd_qevt = hit(rd_ff, addr_ff, isr_pkg::OFF_QEVT);
   assign rd_errq = hit(rd_ff, addr_ff, isr_pkg::OFF_ERRQ);
   assign rd_msg = hit(rd_ff, addr_ff, isr_pkg::OFF_MSG);
   assign rd_poll = hit(rd_ff, addr_ff, isr_pkg::OFF_POLL);

   assign cls_w = wr_cmd && wd[isr_pkg::CMD_CLS];
   assign opc_cmd_w = wr_cmd && wd[isr_pkg::CMD_OPC];
   assign opcq_cmd_w = wr_cmd && wd[isr_pkg::CMD_OPCQ];
   assign dcl_w = (wr_cmd && wd[isr_pkg::CMD_DCL]) || ctrl_c;
   assign wai_cmd_w = wr_cmd && wd[isr_pkg::CMD_WAI];

   // -------------------------------------------------
   // output buffer
   // -------------------------------------------------
   assign obuf_full_w = (ocnt_ff == 4'(isr_pkg::OBUF_DEPTH));
   assign obuf_empty_w = (ocnt_ff == 4'h0);
   assign opc_done_w = opc_pend_ff && !ops_pending;
   assign opcq_done_w = opcq_pend_ff && !ops_pending && !obuf_full_w;
   assign opcq_push_w = opcq_done_w;
   assign obuf_push_w = !dcl_w && !obuf_full_w && (opcq_push_w || resp_push);
   assign obuf_pop_w = !dcl_w && rd_msg && !obuf_empty_w;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         orp_ff <= 3'h0;
         owp_ff <= 3'h0;
         ocnt_ff <= 4'h0;
      end
      else if (dcl_w)
      begin
         orp_ff <= 3'h0;
         owp_ff <= 3'h0;
         ocnt_ff <= 4'h0;
      end
      else
      begin
         if (obuf_push_w)
            owp_ff <= owp_ff + 3'h1;
         if (obuf_pop_w)
            orp_ff <= orp_ff + 3'h1;
         ocnt_ff <= ocnt_ff + 4'(obuf_push_w) - 4'(obuf_pop_w);
      end
   end

   always_ff @(posedge hclk)
   begin
      if (obuf_push_w)
         obuf_ff[owp_ff] <= opcq_push_w ? isr_pkg::OPCQ_REPLY : resp_byte;
   end

   // -------------------------------------------------
   // status byte
   // -------------------------------------------------
   assign ques_sum_w = |(qevt_ff & qena_ff);
   assign esb_sum_w = |(esr_ff & ese_ff);
   assign stb_w = {1'b0, rqs_ff, esb_sum_w, !obuf_empty_w, ques_sum_w, 3'h0};
   assign summ_req_w = |(stb_w & sre_ff & 8'h38);

   // -------------------------------------------------
   // event and mask registers
   // -------------------------------------------------
   logic [7:0] esr_set_w;
   assign esr_set_w = ((wr_evset ? wd : 8'h00) | {pwr_ff, 6'h00, opc_done_w})
      & isr_pkg::ESR_USED;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         esr_ff <= isr_pkg::RST_BYTE;
         qevt_ff <= isr_pkg::RST_BYTE;
         qcond_ff <= 2'h0;
         pwr_ff <= 1'b0;
      end
      else
      begin
         pwr_ff <= power_on;
         qcond_ff <= reg_state;
         // set wins over the clear in the same cycle
         esr_ff <= ((cls_w || rd_esr) ? 8'h00 : esr_ff) | esr_set_w;
         qevt_ff <= ((cls_w || rd_qevt) ? 8'h00 : qevt_ff)
            | ({6'h00, reg_state} & isr_pkg::QUES_USED);
      end
   end

   // masks zero on reset; power-on clears sre and ese only with the flag set
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sre_ff <= isr_pkg::RST_BYTE;
         ese_ff <= isr_pkg::RST_BYTE;
         qena_ff <= isr_pkg::RST_BYTE;
         psc_ff <= isr_pkg::RST_PSC;
      end
      else
      begin
         if (power_on && psc_ff)
         begin
            sre_ff <= 8'h00;
            ese_ff <= 8'h00;
         end
         else
         begin
            if (wr_sre)
               sre_ff <= wd & 8'h38;
            if (wr_ese)
               ese_ff <= wd & isr_pkg::ESR_USED;
         end
         if (wr_qena)
            qena_ff <= wd & isr_pkg::QUES_USED;
         if (wr_psc)
            psc_ff <= wd[0];
      end
   end

   // -------------------------------------------------
   // service request and command flow
   // -------------------------------------------------
   logic summ_d_ff;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         summ_d_ff <= 1'b0;
         rqs_ff <= 1'b0;
         srq_ff <= 1'b0;
         opc_pend_ff <= 1'b0;
         opcq_pend_ff <= 1'b0;
         wai_ff <= 1'b0;
         trig_mode_ff <= 1'b0;
         dtr_ff <= 1'b0;
         flush_ff <= 1'b0;
         err_led_ff <= 1'b0;
      end
      else
      begin
         summ_d_ff <= summ_req_w;
         if (summ_req_w && !summ_d_ff)
            rqs_ff <= 1'b1;
         else if (rd_poll || cls_w || !summ_req_w)
            rqs_ff <= 1'b0;
         srq_ff <= (summ_req_w && !summ_d_ff) || (rqs_ff && !rd_poll && !cls_w && summ_req_w);
         if (opc_cmd_w)
            opc_pend_ff <= 1'b1;
         else if (opc_done_w)
            opc_pend_ff <= 1'b0;
         if (opcq_cmd_w)
            opcq_pend_ff <= 1'b1;
         else if (opcq_done_w || dcl_w)
            opcq_pend_ff <= 1'b0;
         if (wr_cmd)
            trig_mode_ff <= wd[isr_pkg::CMD_TRIGMODE];
         if (wai_cmd_w && (wr_cmd ? wd[isr_pkg::CMD_TRIGMODE] : trig_mode_ff))
            wai_ff <= 1'b1;
         else if (!ops_pending)
            wai_ff <= 1'b0;
         if (dcl_w)
            dtr_ff <= 1'b1;
         flush_ff <= dcl_w;
         err_led_ff <= !eq.empty || err_push;
      end
   end

   assign eq.push = err_push;
   assign eq.push_code = err_code;
   assign eq.pop = rd_errq;
   assign eq.flush = cls_w;

   // -------------------------------------------------
   // read mux
   // -------------------------------------------------
   logic [31:0] rmux_w;
   assign rmux_w =
      (addr_ff == isr_pkg::OFF_STB) ? {24'h0, stb_w} :
      (addr_ff == isr_pkg::OFF_POLL) ? {24'h0, stb_w} :
      (addr_ff == isr_pkg::OFF_SRE) ? {24'h0, sre_ff} :
      (addr_ff == isr_pkg::OFF_ESR) ? {24'h0, esr_ff} :
      (addr_ff == isr_pkg::OFF_ESE) ? {24'h0, ese_ff} :
      (addr_ff == isr_pkg::OFF_QCOND) ? {30'h0, qcond_ff} :
      (addr_ff == isr_pkg::OFF_QEVT) ? {24'h0, qevt_ff} :
      (addr_ff == isr_pkg::OFF_QENA) ? {24'h0, qena_ff} :
      (addr_ff == isr_pkg::OFF_PSC) ? {31'h0, psc_ff} :
      (addr_ff == isr_pkg::OFF_ERRQ) ? {16'h0, eq.head} :
      (addr_ff == isr_pkg::OFF_MSG) ? {24'h0, obuf_empty_w ? 8'h00 : obuf_ff[orp_ff]} :
      (addr_ff == isr_pkg::OFF_STAT) ? {28'h0, wai_ff, obuf_full_w, !eq.empty, opc_pend_ff} :
      32'h0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff <= 32'h0;
         hreadyout_ff <= 1'b1;
      end
      else
      begin
         // reads take one wait state so that hrdata leaves a flop
         hreadyout_ff <= !(take_w && !hwrite);
         if (rd_ff)
            hrdata_ff <= rmux_w;
      end
   end

   logic cmd_hold_ff;
   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = 1'b0;
   assign srq_out = srq_ff;
   assign error_led = err_led_ff;
   assign cmd_hold = cmd_hold_ff;
   assign dtr_out = dtr_ff;
   assign obuf_flush = flush_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cmd_hold_ff <= 1'b0;
      else
         cmd_hold_ff <= (obuf_full_w && (opc_pend_ff || opcq_pend_ff)) || wai_ff;
   end

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   a_mav_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(stb_w[isr_pkg::STB_MAV]) |-> $past(obuf_pop_w || dcl_w))
      else $error("mav dropped with bytes unread");
   a_opc_sets: assert property (@(posedge hclk) disable iff (!hresetn)
      opc_done_w |=> esr_ff[isr_pkg::ESR_OPC]) else $error("opc not set");
   a_opcq_reply: assert property (@(posedge hclk) disable iff (!hresetn)
      opcq_done_w && !dcl_w |=> ocnt_ff != 4'h0) else $error("opc query lost");
   a_qcond_live: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 qcond_ff == $past(reg_state)) else $error("condition stale");
   a_qevt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_qevt |=> qevt_ff == ($past(reg_state) & 8'h03)) else $error("qevt not cleared");
   a_cls_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      cls_w && !wr_evset && !pwr_ff && !opc_done_w |=> esr_ff == 8'h00)
      else $error("cls left events");
   a_poll_rqs: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_poll && !(summ_req_w && !summ_d_ff) |=> !rqs_ff) else $error("poll kept rqs");
   a_stb_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_ff && (addr_ff == isr_pkg::OFF_STB) |=> hrdata_ff[2:0] == 3'h0 && !hrdata_ff[7])
      else $error("reserved stb bits set");
   a_dcl_dtr: assert property (@(posedge hclk) disable iff (!hresetn)
      dcl_w |=> dtr_ff && obuf_empty_w) else $error("device clear incomplete");
   c_srq: cover property (@(posedge hclk) disable iff (!hresetn) srq_ff);
   c_opcq: cover property (@(posedge hclk) disable iff (!hresetn) opcq_done_w);
   c_hold: cover property (@(posedge hclk) disable iff (!hresetn) cmd_hold_ff);
endmodule

// >>> sim/isr_host_model.sv
// ahb-lite master standing in for the remote bus controller
module isr_host_model
(
   // clock
   input wire logic hclk,
   // ahb-lite master side
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end

   // ----------------------------------------
   // one single word transfer
   // ----------------------------------------
   // hwdata is inverted on reads so a stale word never looks valid
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wr ? d : ~hwdata;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      q = hrdata;
   endtask
endmodule

// >>> sim/isr_status_test.sv
// self-checking bench for the status reporting unit
module isr_status_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic hclk;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [1:0] reg_state = 2'b00;
   logic ops_pending = 1'b0;
   logic power_on = 1'b0;
   logic ctrl_c = 1'b0;
   logic [15:0] err_code = 16'h0000;
   logic err_push = 1'b0;
   logic [7:0] resp_byte = 8'h00;
   logic resp_push = 1'b0;
   logic srq_out, error_led, cmd_hold, dtr_out, obuf_flush;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;

   // single slave: its ready is the bus ready
   assign hready = hreadyout;

   isr_host_model i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

   isr_status i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reg_state(reg_state),
      .ops_pending(ops_pending), .power_on(power_on), .ctrl_c(ctrl_c),
      .err_code(err_code), .err_push(err_push), .resp_byte(resp_byte),
      .resp_push(resp_push), .srq_out(srq_out), .error_led(error_led),
      .cmd_hold(cmd_hold), .dtr_out(dtr_out), .obuf_flush(obuf_flush));

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      i_host.xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      i_host.xfer(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic set_ops(input logic v);
      @(posedge hclk);
      ops_pending <= v;
   endtask

   task automatic set_state(input int s);
      @(posedge hclk);
      reg_state <= 2'(s);
   endtask

   task automatic pon();
      @(posedge hclk);
      power_on <= 1'b1;
      @(posedge hclk);
      power_on <= 1'b0;
   endtask

   task automatic push_err(input logic [15:0] c);
      @(posedge hclk);
      err_code <= c;
      err_push <= 1'b1;
      @(posedge hclk);
      err_push <= 1'b0;
   endtask

   task automatic push_resp(input logic [7:0] b);
      @(posedge hclk);
      resp_byte <= b;
      resp_push <= 1'b1;
      @(posedge hclk);
      resp_push <= 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(hresp, 1'b0);
      rd(isr_pkg::OFF_STB, 32'h0);
      rd(isr_pkg::OFF_PSC, 32'h1);
      rd(8'h3C, 32'h0);
   endtask

   task automatic t_power_on();
      wr(isr_pkg::OFF_SRE, 32'h20);
      wr(isr_pkg::OFF_ESE, 32'h21);
      pon();
      rd(isr_pkg::OFF_SRE, 32'h0);
      rd(isr_pkg::OFF_ESE, 32'h0);
      rd(isr_pkg::OFF_ESR, 32'h80);
      wr(isr_pkg::OFF_PSC, 32'h0);
      rd(isr_pkg::OFF_PSC, 32'h0);
      wr(isr_pkg::OFF_SRE, 32'h20);
      wr(isr_pkg::OFF_ESE, 32'h21);
      pon();
      rd(isr_pkg::OFF_SRE, 32'h20);
      rd(isr_pkg::OFF_ESE, 32'h21);
      rd(isr_pkg::OFF_ESR, 32'h80);
   endtask

   task automatic t_masks();
      wr(isr_pkg::OFF_ESE, 32'h3C);
      rd(isr_pkg::OFF_ESE, 32'h3C);
      wr(isr_pkg::OFF_SRE, 32'hFFFFFF18);
      rd(isr_pkg::OFF_SRE, 32'h18);
   endtask

   // controller set-up order: clear, masks, then operation complete
   task automatic t_opc_srq();
      wr(isr_pkg::OFF_CMD, 32'h01);
      wr(isr_pkg::OFF_ESE, 32'h01);
      wr(isr_pkg::OFF_SRE, 32'h20);
      wr(isr_pkg::OFF_EVSET, 32'h20);
      rd(isr_pkg::OFF_STB, 32'h0);
      rd(isr_pkg::OFF_ESR, 32'h20);
      wr(isr_pkg::OFF_CMD, 32'h02);
      idle(4);
      chk(srq_out, 1'b1);
      rd(isr_pkg::OFF_STB, 32'h60);
      rd(isr_pkg::OFF_STB, 32'h60);
      rd(isr_pkg::OFF_POLL, 32'h60);
      rd(isr_pkg::OFF_STB, 32'h20);
      rd(isr_pkg::OFF_ESR, 32'h01);
      rd(isr_pkg::OFF_STB, 32'h0);
      chk(srq_out, 1'b0);
   endtask

   task automatic t_opc_query();
      set_ops(1'b1);
      wr(isr_pkg::OFF_CMD, 32'h04);
      idle(4);
      rd(isr_pkg::OFF_STB, 32'h0);
      set_ops(1'b0);
      idle(4);
      rd(isr_pkg::OFF_STB, 32'h10);
      push_resp(8'h5A);
      rd(isr_pkg::OFF_MSG, 32'h01);
      rd(isr_pkg::OFF_STB, 32'h10);
      rd(isr_pkg::OFF_MSG, 32'h5A);
      rd(isr_pkg::OFF_STB, 32'h0);
   endtask

   task automatic t_ques();
      for (int s = 0; s < 4; s++)
      begin
         set_state(s);
         rd(isr_pkg::OFF_QCOND, 32'(s));
      end
      set_state(0);
      rd(isr_pkg::OFF_QEVT, 32'h3);
      rd(isr_pkg::OFF_QEVT, 32'h0);
      wr(isr_pkg::OFF_QENA, 32'h2);
      set_state(1);
      set_state(0);
      rd(isr_pkg::OFF_STB, 32'h0);
      rd(isr_pkg::OFF_QEVT, 32'h1);
      set_state(2);
      set_state(0);
      rd(isr_pkg::OFF_STB, 32'h08);
      rd(isr_pkg::OFF_QEVT, 32'h2);
      rd(isr_pkg::OFF_STB, 32'h0);
   endtask

   // one more than the depth: the newest slot turns into the overflow record
   task automatic t_errq();
      for (int i = 1; i <= 21; i++)
         push_err(16'(i));
      idle(2);
      chk(error_led, 1'b1);
      for (int i = 1; i <= 19; i++)
         rd(isr_pkg::OFF_ERRQ, 32'(i));
      rd(isr_pkg::OFF_ERRQ, 32'(isr_pkg::ERR_OVERFLOW));
      idle(2);
      chk(error_led, 1'b0);
      rd(isr_pkg::OFF_ERRQ, 32'h0);
   endtask

   task automatic t_cls();
      wr(isr_pkg::OFF_EVSET, 32'hFF);
      rd(isr_pkg::OFF_ESR, 32'hBD);
      wr(isr_pkg::OFF_EVSET, 32'hFF);
      set_state(1);
      set_state(0);
      wr(isr_pkg::OFF_CMD, 32'h01);
      rd(isr_pkg::OFF_ESR, 32'h0);
      rd(isr_pkg::OFF_QEVT, 32'h0);
      rd(isr_pkg::OFF_STB, 32'h0);
   endtask

   task automatic t_dev_clear();
      int n;
      chk(dtr_out, 1'b0);
      set_ops(1'b1);
      wr(isr_pkg::OFF_CMD, 32'h02);
      for (int i = 0; i < isr_pkg::OBUF_DEPTH; i++)
         push_resp(8'(i));
      idle(2);
      chk(cmd_hold, 1'b1);
      @(posedge hclk);
      ctrl_c <= 1'b1;
      @(posedge hclk);
      ctrl_c <= 1'b0;
      n = 0;
      while (obuf_flush !== 1'b1 && n < 8)
      begin
         @(posedge hclk);
         n++;
      end
      chk(obuf_flush, 1'b1);
      idle(2);
      chk(dtr_out, 1'b1);
      chk(cmd_hold, 1'b0);
      rd(isr_pkg::OFF_STB, 32'h0);
      rd(isr_pkg::OFF_ESE, 32'h01);
      set_ops(1'b0);
      idle(4);
   endtask

   task automatic t_wait();
      set_ops(1'b1);
      wr(isr_pkg::OFF_CMD, 32'h10);
      idle(2);
      chk(cmd_hold, 1'b0);
      wr(isr_pkg::OFF_CMD, 32'h30);
      idle(2);
      chk(cmd_hold, 1'b1);
      set_ops(1'b0);
      idle(4);
      chk(cmd_hold, 1'b0);
   endtask

   // ----------------------------------------
   // verdict and main sequence
   // ----------------------------------------
   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // the whole run needs a few hundred cycles
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         final_report();
      end
   end

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_power_on();
      t_masks();
      t_opc_srq();
      t_opc_query();
      t_ques();
      t_errq();
      t_cls();
      t_dev_clear();
      t_wait();
      final_report();
   end
endmodule
